// File: inc/spp_defs.svh
// register map, field positions, reset values and counts of the serial peripheral port
`ifndef SPP_DEFS_SVH
`define SPP_DEFS_SVH

`define SPP_ADDR_W        3
`define SPP_OFS_CTRL1     3'h0
`define SPP_OFS_CTRL2     3'h1
`define SPP_OFS_BAUD      3'h2
`define SPP_OFS_FLAGS     3'h3
`define SPP_OFS_DATA      3'h4
`define SPP_OFS_IRQ_STAT  3'h5
`define SPP_OFS_IRQ_MASK  3'h6

`define SPP_C1_RXIE       7
`define SPP_C1_PORT_EN    6
`define SPP_C1_TXIE       5
`define SPP_C1_MASTER     4
`define SPP_C1_CLOCK_POLARITY       3
`define SPP_C1_CLOCK_PHASE       2
`define SPP_C1_SEL_OE     1
`define SPP_C1_LSB_FIRST  0

`define SPP_C2_FAULT_EN   4
`define SPP_C2_SW_OE      3
`define SPP_C2_HALT_WAIT  1
`define SPP_C2_SINGLE_PIN 0
`define SPP_C2_WR_MASK    8'h1B

`define SPP_BR_PRE_HI     6
`define SPP_BR_PRE_LO     4
`define SPP_BR_RATE_HI    2
`define SPP_BR_RATE_LO    0
`define SPP_BR_WR_MASK    8'h77

`define SPP_FL_RX_FULL    7
`define SPP_FL_TX_EMPTY   5
`define SPP_FL_FAULT      4

`define SPP_IRQ_W         3
`define SPP_IRQ_RX        0
`define SPP_IRQ_TX        1
`define SPP_IRQ_FAULT     2

`define SPP_CTRL1_RST     8'h04
`define SPP_CTRL2_RST     8'h00
`define SPP_BAUD_RST      8'h00
`define SPP_IRQ_MASK_RST  3'h0

`define SPP_DIV_W         11
`define SPP_EDGE_W        5
`define SPP_LAST_EDGE     5'h0F

`endif

// File: inc/spp_pkg.sv
// types shared by the serial peripheral port modules
package spp_pkg;

  typedef logic [7:0] spp_byte_t;

  typedef enum logic [2:0] {
    SPP_IDLE = 3'b001,
    SPP_RUN  = 3'b010,
    SPP_DONE = 3'b100
  } spp_state_t;

endpackage : spp_pkg

// File: inc/spp_shift_if.sv
// bundle between the port controller and its shift engine
`timescale 1ns/100ps
interface spp_shift_if;
  logic             load;
  spp_pkg::spp_byte_t tx_byte;
  logic             shift_en;
  logic             sample_en;
  logic             din;
  logic             lsb_first;
  logic             dout;
  spp_pkg::spp_byte_t rx_byte;

  modport ctrl (output load, tx_byte, shift_en, sample_en, din, lsb_first,
                input  dout, rx_byte);
  modport engine (input  load, tx_byte, shift_en, sample_en, din, lsb_first,
                  output dout, rx_byte);
endinterface : spp_shift_if

// File: logic/spp_shifter.sv
// eight-bit transmit and receive shift registers of the serial peripheral port
`timescale 1ns/100ps
module spp_shifter (
  input  wire logic    core_clk_in,
  input  wire logic    sys_rst_in,
  spp_shift_if.engine  sh
);

  spp_pkg::spp_byte_t tx_sr_r;
  spp_pkg::spp_byte_t rx_sr_r;

  // tx and rx kept apart so that sampling and shifting may fall on different edges
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_sr_r <= 8'h00;
    end else if (sh.load) begin
      tx_sr_r <= sh.tx_byte;
    end else if (sh.shift_en) begin
      tx_sr_r <= sh.lsb_first ? {1'b0, tx_sr_r[7:1]} : {tx_sr_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_sr_r <= 8'h00;
    end else if (sh.sample_en) begin
      rx_sr_r <= sh.lsb_first ? {sh.din, rx_sr_r[7:1]} : {rx_sr_r[6:0], sh.din};
    end
  end

  assign sh.dout    = sh.lsb_first ? tx_sr_r[0] : tx_sr_r[7];
  assign sh.rx_byte = rx_sr_r;

endmodule : spp_shifter

// File: logic/spp_port.sv
// serial peripheral port: registers, bit clock, master and slave sequencing, pins
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "spp_defs.svh"
module spp_port (
  input  wire logic                  core_clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic [`SPP_ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic      [7:0]            reg_rdata_out,
  output logic                       irq_out,
  input  wire logic                  wait_mode_in,
  input  wire logic                  sclk_in,
  output logic                       sclk_out,
  output logic                       sclk_oe_out,
  input  wire logic                  mosi_in,
  output logic                       mosi_out,
  output logic                       mosi_oe_out,
  input  wire logic                  miso_in,
  output logic                       miso_out,
  output logic                       miso_oe_out,
  input  wire logic                  sel_n_in,
  output logic                       sel_n_out,
  output logic                       sel_n_oe_out
);

  // half a bit period in bus cycles: (prescale+1) * 2^(rate+1) / 2
  function automatic logic [`SPP_DIV_W-1:0] half_period(input logic [7:0] baud);
    logic [`SPP_DIV_W-1:0] pre;
    pre = {8'h00, baud[`SPP_BR_PRE_HI:`SPP_BR_PRE_LO]} + 11'h001;
    return pre << baud[`SPP_BR_RATE_HI:`SPP_BR_RATE_LO];
  endfunction : half_period

  spp_shift_if sh ();

  // registers
  logic [7:0]             ctrl1_r;
  logic [7:0]             ctrl1_nxt;
  logic [7:0]             ctrl2_r;
  logic [7:0]             baud_r;
  spp_pkg::spp_byte_t     tx_buf_r;
  logic                   tx_full_r;
  spp_pkg::spp_byte_t     rx_data_r;
  logic                   rx_full_r;
  logic                   rx_arm_r;
  logic                   fault_r;
  logic                   fault_arm_r;
  logic [`SPP_IRQ_W-1:0]  irq_stat_r;
  logic [`SPP_IRQ_W-1:0]  irq_mask_r;
  spp_pkg::spp_state_t    state_r;
  spp_pkg::spp_state_t    state_nxt;
  logic [`SPP_DIV_W-1:0]  div_cnt_r;
  logic [`SPP_EDGE_W-1:0] edge_cnt_r;
  logic                   sclk_lvl_r;
  logic                   sclk_q_r;
  logic                   xfer_end_r;

  // decoded control fields
  wire port_en    = ctrl1_r[`SPP_C1_PORT_EN];
  wire master     = ctrl1_r[`SPP_C1_MASTER];
  wire clock_polarity       = ctrl1_r[`SPP_C1_CLOCK_POLARITY];
  wire clock_phase       = ctrl1_r[`SPP_C1_CLOCK_PHASE];
  wire sel_oe     = ctrl1_r[`SPP_C1_SEL_OE];
  wire rx_ie      = ctrl1_r[`SPP_C1_RXIE];
  wire tx_ie      = ctrl1_r[`SPP_C1_TXIE];
  wire fault_en   = ctrl2_r[`SPP_C2_FAULT_EN];
  wire sw_oe      = ctrl2_r[`SPP_C2_SW_OE];
  wire halt_wait  = ctrl2_r[`SPP_C2_HALT_WAIT];
  wire single_pin = ctrl2_r[`SPP_C2_SINGLE_PIN];

  // register strobes
  wire wr_c1    = reg_wr_in & (reg_addr_in == `SPP_OFS_CTRL1);
  wire wr_c2    = reg_wr_in & (reg_addr_in == `SPP_OFS_CTRL2);
  wire wr_baud  = reg_wr_in & (reg_addr_in == `SPP_OFS_BAUD);
  wire wr_data  = reg_wr_in & (reg_addr_in == `SPP_OFS_DATA);
  wire wr_istat = reg_wr_in & (reg_addr_in == `SPP_OFS_IRQ_STAT);
  wire wr_imask = reg_wr_in & (reg_addr_in == `SPP_OFS_IRQ_MASK);
  wire rd_flags = reg_rd_in & (reg_addr_in == `SPP_OFS_FLAGS);
  wire rd_data  = reg_rd_in & (reg_addr_in == `SPP_OFS_DATA);

  // role and link state
  wire running   = (state_r == spp_pkg::SPP_RUN);
  wire halted    = halt_wait & wait_mode_in;
  wire fault_now = port_en & master & fault_en & ~sel_oe & ~sel_n_in;
  wire slave_sel = port_en & ~master & ~sel_n_in;
  wire tick      = running & ~halted & (div_cnt_r == 11'h000);

  // slave edges seen against the previous pin level
  wire s_edge  = slave_sel & (sclk_in != sclk_q_r);
  wire s_lead  = s_edge & (sclk_q_r == clock_polarity);
  wire s_trail = s_edge & (sclk_q_r != clock_polarity);
  wire m_lead  = tick & ~edge_cnt_r[0];
  wire m_trail = tick & edge_cnt_r[0];
  wire lead    = master ? m_lead : s_lead;
  wire trail   = master ? m_trail : s_trail;
  wire first   = (edge_cnt_r == 5'h00);
  wire last    = (edge_cnt_r == `SPP_LAST_EDGE);

  // clock_phase clear: sample leading, shift trailing; clock_phase set: shift leading, sample trailing
  wire sample_en = clock_phase ? trail : lead;
  wire shift_en  = clock_phase ? (lead & ~first) : (trail & ~last);
  wire xfer_done = trail & last;

  wire start  = (state_r == spp_pkg::SPP_IDLE) & port_en & master & tx_full_r
              & ~fault_now;
  wire s_load = port_en & ~master & tx_full_r & first & ~s_edge;
  wire load   = start | s_load;

  // separate data pins unless single pin control picks one shared wire
  wire din = master ? (single_pin ? mosi_in : miso_in)
                    : (single_pin ? miso_in : mosi_in);
  wire out_path_en = ~single_pin | sw_oe;

  // sticky interrupt events
  wire [`SPP_IRQ_W-1:0] irq_ev;
  assign irq_ev[`SPP_IRQ_RX]    = xfer_end_r;
  assign irq_ev[`SPP_IRQ_TX]    = load;
  assign irq_ev[`SPP_IRQ_FAULT] = fault_now & ~fault_r;

  wire [`SPP_IRQ_W-1:0] irq_clr  = wr_istat ? reg_wdata_in[`SPP_IRQ_W-1:0] : 3'h0;
  wire [`SPP_IRQ_W-1:0] irq_gate = {1'b1, tx_ie, rx_ie};

  wire [7:0] flags_val = {rx_full_r, 1'b0, ~tx_full_r, fault_r, 4'h0};

  wire [7:0] rdata_nxt =
      ~reg_rd_in                              ? 8'h00 :
      (reg_addr_in == `SPP_OFS_CTRL1)         ? ctrl1_r :
      (reg_addr_in == `SPP_OFS_CTRL2)         ? ctrl2_r :
      (reg_addr_in == `SPP_OFS_BAUD)          ? baud_r :
      (reg_addr_in == `SPP_OFS_FLAGS)         ? flags_val :
      (reg_addr_in == `SPP_OFS_DATA)          ? rx_data_r :
      (reg_addr_in == `SPP_OFS_IRQ_STAT)      ? {5'h00, irq_stat_r} :
      (reg_addr_in == `SPP_OFS_IRQ_MASK)      ? {5'h00, irq_mask_r} : 8'h00;

  // a mode fault drops the port back to slave so two masters stop fighting
  assign ctrl1_nxt = (wr_c1 ? reg_wdata_in : ctrl1_r)
                   & ~(fault_now ? (8'h01 << `SPP_C1_MASTER) : 8'h00);

  // pin drive values, registered below
  wire sclk_oe_nxt = port_en & master;
  wire mosi_oe_nxt = port_en & master & out_path_en;
  wire miso_oe_nxt = slave_sel & out_path_en;
  wire sel_oe_nxt  = port_en & master & sel_oe & fault_en;
  wire sel_n_nxt   = ~(running | (state_r == spp_pkg::SPP_DONE));

  assign sh.load      = load;
  assign sh.tx_byte   = tx_buf_r;
  assign sh.shift_en  = shift_en;
  assign sh.sample_en = sample_en;
  assign sh.din       = din;
  assign sh.lsb_first = ctrl1_r[`SPP_C1_LSB_FIRST];

  spp_shifter u_shifter (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .sh          (sh.engine)
  );

  // master sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      spp_pkg::SPP_IDLE: begin
        if (start) begin
          state_nxt = spp_pkg::SPP_RUN;
        end
      end
      spp_pkg::SPP_RUN: begin
        if (~port_en | ~master | fault_now) begin
          state_nxt = spp_pkg::SPP_IDLE;
        end else if (xfer_done) begin
          state_nxt = spp_pkg::SPP_DONE;
        end
      end
      spp_pkg::SPP_DONE: begin
        state_nxt = spp_pkg::SPP_IDLE;
      end
      default: begin
        state_nxt = spp_pkg::SPP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= spp_pkg::SPP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // divider stands still in wait when halting is asked for
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_cnt_r <= 11'h000;
    end else if (start | tick) begin
      div_cnt_r <= half_period(baud_r) - 11'h001;
    end else if (running & ~halted) begin
      div_cnt_r <= div_cnt_r - 11'h001;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_lvl_r <= 1'b0;
    end else if (running & tick) begin
      sclk_lvl_r <= ~sclk_lvl_r;
    end else if (~running) begin
      sclk_lvl_r <= clock_polarity;
    end
  end

  // one counter serves both roles; a deselected slave restarts at bit zero
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      edge_cnt_r <= 5'h00;
    end else if (~port_en | fault_now | (~master & sel_n_in) | (master & ~running)) begin
      edge_cnt_r <= 5'h00;
    end else if (lead | trail) begin
      edge_cnt_r <= last ? 5'h00 : edge_cnt_r + 5'h01;
    end
  end

  // the final sample lands one cycle after the last edge, so capture after that
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      xfer_end_r <= 1'b0;
      sclk_q_r   <= 1'b0;
    end else begin
      xfer_end_r <= xfer_done;
      sclk_q_r   <= sclk_in;
    end
  end

  // control registers
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl1_r    <= `SPP_CTRL1_RST;
      ctrl2_r    <= `SPP_CTRL2_RST;
      baud_r     <= `SPP_BAUD_RST;
      irq_mask_r <= `SPP_IRQ_MASK_RST;
    end else begin
      ctrl1_r <= ctrl1_nxt;
      if (wr_c2) begin
        ctrl2_r <= reg_wdata_in & `SPP_C2_WR_MASK;
      end
      if (wr_baud) begin
        baud_r <= reg_wdata_in & `SPP_BR_WR_MASK;
      end
      if (wr_imask) begin
        irq_mask_r <= reg_wdata_in[`SPP_IRQ_W-1:0];
      end
    end
  end

  // transmit buffer: a write while a load happens keeps the new byte pending
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_buf_r  <= 8'h00;
      tx_full_r <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_buf_r <= reg_wdata_in;
      end
      tx_full_r <= wr_data | (tx_full_r & ~load);
    end
  end

  // receive side: flags read arms, data read then clears; a new byte wins
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_data_r <= 8'h00;
      rx_full_r <= 1'b0;
      rx_arm_r  <= 1'b0;
    end else begin
      if (xfer_end_r) begin
        rx_data_r <= sh.rx_byte;
      end
      rx_full_r <= xfer_end_r | (rx_full_r & ~(rd_data & rx_arm_r));
      rx_arm_r  <= (rd_flags & rx_full_r) | (rx_arm_r & ~rd_data);
    end
  end

  // fault flag: flags read arms, control one write clears; a new fault wins
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fault_r     <= 1'b0;
      fault_arm_r <= 1'b0;
    end else begin
      fault_r     <= fault_now | (fault_r & ~(wr_c1 & fault_arm_r));
      fault_arm_r <= (rd_flags & fault_r) | (fault_arm_r & ~wr_c1);
    end
  end

  // interrupt status, write one to clear, set wins
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_stat_r <= 3'h0;
    end else begin
      irq_stat_r <= irq_ev | (irq_stat_r & ~irq_clr);
    end
  end

  // all outputs registered; pin timing therefore lags internal state by one cycle
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
      irq_out       <= 1'b0;
      sclk_out      <= 1'b0;
      sclk_oe_out   <= 1'b0;
      mosi_out      <= 1'b0;
      mosi_oe_out   <= 1'b0;
      miso_out      <= 1'b0;
      miso_oe_out   <= 1'b0;
      sel_n_out     <= 1'b1;
      sel_n_oe_out  <= 1'b0;
    end else begin
      reg_rdata_out <= rdata_nxt;
      irq_out       <= |(irq_stat_r & irq_mask_r & irq_gate);
      sclk_out      <= sclk_lvl_r;
      sclk_oe_out   <= sclk_oe_nxt;
      mosi_out      <= sh.dout;
      mosi_oe_out   <= mosi_oe_nxt;
      miso_out      <= sh.dout;
      miso_oe_out   <= miso_oe_nxt;
      sel_n_out     <= sel_n_nxt;
      sel_n_oe_out  <= sel_oe_nxt;
    end
  end

endmodule : spp_port

// File: verif/spp_assertions.sv
// concurrent checks on the serial peripheral port pins and register bus
`timescale 1ns/100ps
`include "spp_defs.svh"
module spp_assertions (
  input wire logic                   core_clk_in,
  input wire logic                   sys_rst_in,
  input wire logic [`SPP_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0]             reg_wdata_in,
  input wire logic                   reg_wr_in,
  input wire logic                   reg_rd_in,
  input wire logic [7:0]             reg_rdata_out,
  input wire logic                   irq_out,
  input wire logic                   sclk_out,
  input wire logic                   sclk_oe_out,
  input wire logic                   mosi_oe_out,
  input wire logic                   miso_oe_out,
  input wire logic                   sel_n_in,
  input wire logic                   sel_n_out
);
  logic [7:0] c1_r;
  logic [4:0] edge_r;
  logic [2:0] quiet_r;
  logic       sclk_r;
  logic [7:0]  br_r;
  logic [10:0] run_r;
  wire  [10:0] half_w = ({8'h00, br_r[`SPP_BR_PRE_HI:`SPP_BR_PRE_LO]} + 11'h001)
                        << br_r[`SPP_BR_RATE_HI:`SPP_BR_RATE_LO];
  // shadow of control one; a mode fault is only provoked with the select line low
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      c1_r    <= `SPP_CTRL1_RST;
      edge_r  <= 5'h00;
      quiet_r <= 3'h0;
      sclk_r  <= 1'b0;
      br_r    <= `SPP_BAUD_RST;
      run_r   <= 11'h000;
    end else begin
      sclk_r  <= sclk_out;
      run_r   <= (sclk_out != sclk_r) ? 11'h001 : run_r + 11'h001;
      if (reg_wr_in && reg_addr_in == `SPP_OFS_BAUD) br_r <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `SPP_OFS_CTRL1) c1_r <= reg_wdata_in;
      edge_r  <= sel_n_out ? 5'h00 : edge_r + 5'(sclk_out ^ sclk_r);
      quiet_r <= ((reg_wr_in && reg_addr_in == `SPP_OFS_CTRL1) || !sel_n_out || !sel_n_in) ?
                 3'h0 : quiet_r + 3'(quiet_r != 3'h7);
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read cycle");
  a_flags_unused: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == `SPP_OFS_FLAGS |-> (reg_rdata_out & 8'h4F) == 8'h00)
    else $error("unused flag bits read nonzero");
  a_ctrl2_unused: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == `SPP_OFS_CTRL2 |-> (reg_rdata_out & 8'hE4) == 8'h00)
    else $error("unused control two bits read nonzero");
  a_baud_unused: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == `SPP_OFS_BAUD |-> (reg_rdata_out & 8'h88) == 8'h00)
    else $error("unused baud bits read nonzero");
  a_sclk_idle: assert property (
    c1_r[6] && c1_r[4] && quiet_r == 3'h7 |-> sclk_out == c1_r[3])
    else $error("idle serial clock differs from polarity");
  a_edge_count: assert property ($rose(sel_n_out) |-> edge_r == 5'h10)
    else $error("frame did not carry sixteen clock edges");
  a_bit_period: assert property (
    !sel_n_out && sclk_out != sclk_r && edge_r != 5'h00 |-> run_r == half_w)
    else $error("serial clock half period differs from baud setting");
  a_tx_start: assert property (
    reg_wr_in && reg_addr_in == `SPP_OFS_DATA && c1_r[6] && c1_r[4] && sel_n_in &&
    sel_n_out && $past(sel_n_out) |-> ##[1:3] !sel_n_out)
    else $error("data write did not start a master frame");
  a_oe_exclusive: assert property (miso_oe_out |-> !mosi_oe_out && !sclk_oe_out)
    else $error("slave and master drivers enabled together");
  a_irq_masked: assert property (
    reg_wr_in && reg_addr_in == `SPP_OFS_IRQ_MASK && reg_wdata_in[2:0] == 3'h0
    |-> ##2 !irq_out [*2])
    else $error("interrupt stayed high with mask cleared");
  cover property ($rose(sel_n_out));
  cover property ($rose(irq_out));
  cover property ($past(reg_rd_in) && $past(reg_addr_in) == `SPP_OFS_FLAGS && reg_rdata_out[4]);
endmodule : spp_assertions

bind spp_port spp_assertions u_chk (.*);

// File: verif/spp_peer.sv
// behavioural serial peer standing on the far side while the port is master
`timescale 1ns/100ps
module spp_peer (
  input  wire logic       sclk_in,
  input  wire logic       sel_n_in,
  input  wire logic       mosi_in,
  input  wire logic       clock_polarity_in,
  input  wire logic       clock_phase_in,
  input  wire logic       lsb_in,
  input  wire logic [7:0] tx_in,
  output logic            miso_out,
  output logic      [7:0] rx_out
);
  int unsigned k;
  logic        sel_q;
  logic        sclk_q;
  function automatic logic pick(input int unsigned i);
    return lsb_in ? tx_in[i] : tx_in[7-i];
  endfunction : pick
  // one process owns both outputs, so each pin event is judged against the last levels
  initial begin
    miso_out = 1'b0;
    rx_out   = 8'h00;
    sel_q    = 1'b1;
    sclk_q   = 1'b0;
    k        = 0;
    forever begin
      @(sclk_in or sel_n_in);
      if (sel_n_in !== sel_q && !sel_n_in) begin
        k = 0;
        if (!clock_phase_in) begin
          miso_out = pick(0);
          k = 1;
        end
      end else if (sel_n_in !== sel_q) begin
        // released line flips so a stale bit can never pass for a fresh one
        miso_out = ~miso_out;
      end else if (!sel_n_in && sclk_in !== sclk_q) begin
        if ((sclk_in != clock_polarity_in) ^ clock_phase_in) begin
          rx_out = lsb_in ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
        end else if (k < 8) begin
          miso_out = pick(k);
          k = k + 1;
        end
      end
      sel_q  = sel_n_in;
      sclk_q = sclk_in;
    end
  end
endmodule : spp_peer

// File: verif/tb_top.sv
// self-checking bench for the serial peripheral port in master and slave roles
`timescale 1ns/100ps
`include "spp_defs.svh"
module tb_top;
  logic                   clk, rst, wr, rd, sel_tb, wmode, clock_polarity, clock_phase, lsb;
  logic [`SPP_ADDR_W-1:0] addr;
  logic [7:0]             wd, rdata, ptx, prx;
  logic                   irq, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_w, sel_o, sel_oe;
  logic                   sck_w, mosi_w, psel, sel_w, sck_tb, mosi_tb, miso_o, miso_oe;
  int                     err_count, total_checks, cycles;
  assign sck_w  = sclk_oe ? sclk_o : sck_tb;
  assign mosi_w = mosi_oe ? mosi_o : mosi_tb;
  assign psel   = sel_oe ? sel_o : 1'b1;
  assign sel_w  = sel_oe ? sel_o : sel_tb;
  spp_port uut (
    .core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq),
    .wait_mode_in(wmode), .sclk_in(sck_w), .sclk_out(sclk_o), .sclk_oe_out(sclk_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_o), .miso_oe_out(miso_oe), .sel_n_in(sel_w), .sel_n_out(sel_o),
    .sel_n_oe_out(sel_oe));
  spp_peer peer (
    .sclk_in(sck_w), .sel_n_in(psel), .mosi_in(mosi_w), .clock_polarity_in(clock_polarity), .clock_phase_in(clock_phase),
    .lsb_in(lsb), .tx_in(ptx), .miso_out(miso_w), .rx_out(prx));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr   <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] v;
    rd_reg(a, v);
    chk(nm, v, exp);
  endtask : rd_chk
  initial begin
    int         m, n;
    logic [7:0] v, sb;
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 3'h0; wd = 8'h00; sel_tb = 1'b1; wmode = 1'b0;
    clock_polarity = 1'b0; clock_phase = 1'b0; lsb = 1'b0; ptx = 8'h00; sck_tb = 1'b0; mosi_tb = 1'b0;
    err_count = 0; total_checks = 0; cycles = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`SPP_OFS_CTRL1, 8'h04, "ctrl1 reset");
    rd_chk(`SPP_OFS_CTRL2, 8'h00, "ctrl2 reset");
    rd_chk(`SPP_OFS_BAUD, 8'h00, "baud reset");
    rd_chk(`SPP_OFS_FLAGS, 8'h20, "flags reset");
    rd_chk(`SPP_OFS_IRQ_MASK, 8'h00, "mask reset");
    wr_reg(`SPP_OFS_CTRL1, 8'hBF);
    rd_chk(`SPP_OFS_CTRL1, 8'hBF, "ctrl1 rw");
    wr_reg(`SPP_OFS_CTRL2, 8'hFF);
    rd_chk(`SPP_OFS_CTRL2, 8'h1B, "ctrl2 mask");
    wr_reg(`SPP_OFS_BAUD, 8'hFF);
    rd_chk(`SPP_OFS_BAUD, 8'h77, "baud mask");
    wr_reg(`SPP_OFS_FLAGS, 8'hFF);
    rd_chk(`SPP_OFS_FLAGS, 8'h20, "flags read only");
    wr_reg(3'h7, 8'hFF);
    rd_chk(3'h7, 8'h00, "unmapped");
    $display("test reset_access done");
    wr_reg(`SPP_OFS_CTRL2, 8'h10);
    wr_reg(`SPP_OFS_BAUD, 8'h11);
    wr_reg(`SPP_OFS_IRQ_MASK, 8'h01);
    for (m = 0; m < 8; m++) begin
      clock_polarity = m[2];
      clock_phase = m[1];
      lsb  = m[0];
      sb   = 8'h96 ^ 8'(m * 29);
      ptx  = ~sb ^ 8'(m);
      wr_reg(`SPP_OFS_CTRL1, {1'b1, 1'b1, 1'b0, 1'b1, clock_polarity, clock_phase, 1'b1, lsb});
      wr_reg(`SPP_OFS_DATA, sb);
      n = 0;
      do begin
        rd_reg(`SPP_OFS_IRQ_STAT, v);
        n++;
      end while (v[0] !== 1'b1 && n < 200);
      chk("irq raised", {7'h00, irq}, 8'h01);
      chk("peer rx", prx, sb);
      rd_chk(`SPP_OFS_DATA, ptx, "rx data");
      rd_chk(`SPP_OFS_FLAGS, 8'hA0, "full kept");
      rd_chk(`SPP_OFS_DATA, ptx, "rx again");
      rd_chk(`SPP_OFS_FLAGS, 8'h20, "full cleared");
      wr_reg(`SPP_OFS_IRQ_STAT, 8'h03);
      repeat (2) @(posedge clk);
      chk("irq cleared", {7'h00, irq}, 8'h00);
    end
    $display("test master_modes done");
    wr_reg(`SPP_OFS_IRQ_MASK, 8'h04);
    wr_reg(`SPP_OFS_CTRL1, 8'h50);
    @(posedge clk);
    sel_tb <= 1'b0;
    repeat (3) @(posedge clk);
    chk("fault irq", {7'h00, irq}, 8'h01);
    rd_chk(`SPP_OFS_IRQ_STAT, 8'h04, "fault event");
    rd_chk(`SPP_OFS_CTRL1, 8'h40, "master dropped");
    rd_chk(`SPP_OFS_FLAGS, 8'h30, "fault flag");
    @(posedge clk);
    sel_tb <= 1'b1;
    wr_reg(`SPP_OFS_CTRL1, 8'h40);
    rd_chk(`SPP_OFS_FLAGS, 8'h20, "fault cleared");
    wr_reg(`SPP_OFS_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr_reg(`SPP_OFS_IRQ_STAT, 8'h04);
    wr_reg(`SPP_OFS_IRQ_MASK, 8'h04);
    repeat (2) @(posedge clk);
    chk("irq after clear", {7'h00, irq}, 8'h00);
    $display("test fault_irq done");
    // slave role: the bench is the master, each clock phase held four bus cycles
    wr_reg(`SPP_OFS_CTRL1, 8'hC0);
    wr_reg(`SPP_OFS_DATA, 8'hC3);
    sel_tb <= 1'b0;
    sb = 8'h3C;
    for (m = 7; m >= 0; m--) begin
      mosi_tb <= sb[m];
      repeat (4) @(posedge clk);
      v[m] = miso_o;
      sck_tb <= 1'b1;
      repeat (4) @(posedge clk);
      sck_tb <= 1'b0;
    end
    chk("miso drive", {7'h00, miso_oe}, 8'h01);
    repeat (2) @(posedge clk);
    sel_tb <= 1'b1;
    chk("slave tx", v, 8'hC3);
    rd_chk(`SPP_OFS_DATA, 8'h3C, "slave rx");
    $display("test slave_role done");
    close_out();
  end
endmodule : tb_top
